// ---- common/vcs_pkg.sv ----
// Purpose: constants and types of the video capture DMA sequencer
// Assumes: 32-bit instruction words, 50 MHz system clock
// Notes: codes with no fixed value are plain defaults
`default_nettype none
package vcs_pkg;
   localparam logic [7:0] REG_START = 8'h00;
   localparam logic [7:0] REG_CTRL = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_FLAGS = 8'h0c;
   localparam logic [7:0] REG_PC = 8'h10;
   localparam logic [31:0] START_RST = 32'h0000_0000;
   localparam logic [3:0] OP_WRITE = 4'h1;
   localparam logic [3:0] OP_CONT = 4'h5;
   localparam logic [3:0] OP_PLANAR = 4'h9;
   localparam logic [3:0] OP_SKIP = 4'h2;
   localparam logic [3:0] OP_JUMP = 4'h7;
   localparam logic [3:0] OP_SYNC = 4'h8;
   localparam logic [2:0] NW_WRITE = 3'h2;
   localparam logic [2:0] NW_PLANAR = 3'h5;
   localparam logic [2:0] NW_JUMP = 3'h2;
   localparam logic [2:0] NW_ONE = 3'h1;
   localparam int OP_HI = 31;
   localparam int OP_LO = 28;
   localparam int SOL_BIT = 27;
   localparam int EOL_BIT = 26;
   localparam int IRQ_BIT = 24;
   localparam int SET_HI = 23;
   localparam int SET_LO = 20;
   localparam int CLR_HI = 19;
   localparam int CLR_LO = 16;
   localparam int BE_HI = 15;
   localparam int BE_LO = 12;
   localparam int CNT_HI = 11;
   localparam int CNT_LO = 0;
   localparam int CNT3_HI = 27;
   localparam int CNT3_LO = 16;
   localparam int CODE_HI = 3;
   localparam int CODE_LO = 0;
   localparam logic [3:0] CODE_PACKED = 4'h2;
   localparam logic [3:0] CODE_PLANAR = 4'h3;
   localparam logic [3:0] CODE_EVEN = 4'hc;
   localparam logic [3:0] CODE_ODD = 4'hd;
   localparam int FL_IRQ = 0;
   localparam int FL_OVF = 1;
   localparam int FL_MIS = 2;
   localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_FETCH = 6'h02,
      ST_DECODE = 6'h04,
      ST_XFER = 6'h08,
      ST_SYNC = 6'h10,
      ST_DONE = 6'h20
   } vcs_state_t;
endpackage : vcs_pkg
`default_nettype wire

// ---- hw/vcs_plane_chan.sv ----
// Purpose: address and byte count of one queue's segment
// Assumes: segment addresses are word aligned
// Notes: last word carries a partial byte mask unless the count is a multiple of 4
`default_nettype none
module vcs_plane_chan #(
   parameter int CW = 12
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic load,
   input wire logic load_addr_en,
   input wire logic [31:0] load_addr,
   input wire logic [CW-1:0] load_count,
   input wire logic step,
   output logic [31:0] addr_q,
   output logic [CW-1:0] count_q,
   output logic [3:0] be_mask,
   output logic done
);
   logic [31:0] addr_d;
   logic [CW-1:0] count_d;

   always_comb begin
      addr_d = addr_q;
      count_d = count_q;
      if (load) begin
         count_d = load_count;
         if (load_addr_en) begin
            addr_d = load_addr;
         end
      end else if (step) begin
         addr_d = addr_q + vcs_pkg::WORD_BYTES;
         count_d = (count_q > CW'(4)) ? count_q - CW'(4) : '0;
      end
   end

   always_comb begin
      unique case (count_q)
         CW'(0): be_mask = 4'h0;
         CW'(1): be_mask = 4'h1;
         CW'(2): be_mask = 4'h3;
         CW'(3): be_mask = 4'h7;
         default: be_mask = 4'hf;
      endcase
   end

   assign done = (count_q == '0);

   always_ff @(posedge clk) begin
      if (srst) begin
         addr_q <= '0;
         count_q <= '0;
      end else begin
         addr_q <= addr_d;
         count_q <= count_d;
      end
   end
endmodule : vcs_plane_chan
`default_nettype wire

// ---- hw/vcs_dma_seq.sv ----
// Purpose: instruction driven DMA sequencer draining pixel queues
// Assumes: queues and bus initiator run on clk
// Notes: q_rd is combinational so a full queue is read at once
//
// Chosen here: the placing of the registers and the strobed register port.
`default_nettype none
module vcs_dma_seq #(
   parameter int CW = 12
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic fetch_req,
   output logic [31:0] fetch_addr,
   input wire logic fetch_ack,
   input wire logic [31:0] fetch_data,
   input wire logic [2:0][31:0] q_data,
   input wire logic [2:0] q_empty,
   input wire logic [2:0] queue_full_flag,
   input wire logic q_is_code,
   output logic [2:0] q_rd,
   output logic wr_valid,
   output logic [31:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_be,
   output logic line_begin_flag,
   output logic line_end_flag,
   input wire logic wr_ready
);
   vcs_pkg::vcs_state_t state_q, state_d;
   logic [31:0] start_q, start_d;
   logic run_q, run_d, run_prev_q;
   logic [2:0] flags_q, flags_d;
   logic [3:0] sts_q, sts_d;
   logic mode_q, mode_d;
   logic [31:0] pc_q, pc_d;
   logic [31:0] ins_q [0:4];
   logic [31:0] ins_d [0:4];
   logic [2:0] widx_q, widx_d;
   logic [1:0] cur_q, cur_d;
   logic drop_q, drop_d;
   logic first_q, first_d;
   logic fetch_req_q, fetch_req_d;
   logic [31:0] fetch_addr_q, fetch_addr_d;
   logic wr_valid_q, wr_valid_d;
   logic [31:0] wr_addr_q, wr_addr_d;
   logic [31:0] wr_data_q, wr_data_d;
   logic [3:0] wr_be_q, wr_be_d;
   logic sol_q, sol_d, eol_q, eol_d;
   logic [31:0] rdata_q, rdata_d;
   logic [2:0] ch_load, ch_step, ch_done;
   logic ch_addr_en;
   logic [2:0][31:0] ch_lda, ch_addr;
   logic [2:0][CW-1:0] ch_ldc, ch_cnt;
   logic [2:0][3:0] ch_be;
   logic [3:0] op;
   logic [2:0] nw;
   logic [31:0] head_word, cur_addr, jump_tgt;
   logic [CW-1:0] cnt2_w, cnt3_w;
   logic take, sync_pop, sync_match, code_pop, last_chan;
   logic [2:0] took;

   function automatic logic [2:0] words_of(input logic [3:0] o);
      logic [2:0] n;
      n = vcs_pkg::NW_ONE;
      if (o == vcs_pkg::OP_WRITE) n = vcs_pkg::NW_WRITE;
      if (o == vcs_pkg::OP_PLANAR) n = vcs_pkg::NW_PLANAR;
      if (o == vcs_pkg::OP_JUMP) n = vcs_pkg::NW_JUMP;
      return n;
   endfunction : words_of

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_chan
         vcs_plane_chan #(.CW(CW)) u_chan (
            .clk(clk),
            .srst(srst),
            .load(ch_load[g]),
            .load_addr_en(ch_addr_en),
            .load_addr(ch_lda[g]),
            .load_count(ch_ldc[g]),
            .step(ch_step[g]),
            .addr_q(ch_addr[g]),
            .count_q(ch_cnt[g]),
            .be_mask(ch_be[g]),
            .done(ch_done[g])
         );
      end
   endgenerate

   assign op = ins_q[0][vcs_pkg::OP_HI:vcs_pkg::OP_LO];
   assign nw = words_of(widx_q == 3'h0 ?
      fetch_data[vcs_pkg::OP_HI:vcs_pkg::OP_LO] : op);
   assign head_word = q_data[cur_q];
   assign cur_addr = ch_addr[cur_q];
   assign jump_tgt = ins_q[1];
   assign cnt2_w = ins_q[1][vcs_pkg::CNT_HI:vcs_pkg::CNT_LO];
   assign cnt3_w = ins_q[1][vcs_pkg::CNT3_HI:vcs_pkg::CNT3_LO];
   assign last_chan = (op != vcs_pkg::OP_PLANAR) || (cur_q == 2'h2);
   // Code words stall a transfer; only a sync or a full-queue read may consume them
   assign take = (state_q == vcs_pkg::ST_XFER) && !ch_done[cur_q]
      && !q_empty[cur_q] && !(cur_q == 2'h0 && q_is_code)
      && (drop_q || !wr_valid_q || wr_ready);
   assign sync_pop = (state_q == vcs_pkg::ST_SYNC) && !q_empty[0];
   assign sync_match = sync_pop && q_is_code
      && q_data[0][vcs_pkg::CODE_HI:vcs_pkg::CODE_LO]
      == ins_q[0][vcs_pkg::CODE_HI:vcs_pkg::CODE_LO];
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         took[i] = take && (cur_q == 2'(i));
      end
      took[0] = took[0] | sync_pop;
   end
   assign ch_step = took & {3{state_q == vcs_pkg::ST_XFER}};
   // A full queue is read now; the word is lost if nobody takes it
   assign q_rd = took | queue_full_flag;
   assign code_pop = q_rd[0] && q_is_code;

   always_comb begin
      state_d = state_q;
      start_d = start_q;
      run_d = run_q;
      flags_d = flags_q;
      sts_d = sts_q;
      mode_d = mode_q;
      pc_d = pc_q;
      for (int i = 0; i < 5; i++) begin
         ins_d[i] = ins_q[i];
      end
      widx_d = widx_q;
      cur_d = cur_q;
      drop_d = drop_q;
      first_d = first_q;
      fetch_req_d = fetch_req_q;
      fetch_addr_d = fetch_addr_q;
      wr_valid_d = wr_valid_q && !wr_ready;
      wr_addr_d = wr_addr_q;
      wr_data_d = wr_data_q;
      wr_be_d = wr_be_q;
      sol_d = sol_q;
      eol_d = eol_q;
      rdata_d = '0;
      ch_load = '0;
      ch_addr_en = 1'b1;
      ch_lda = '0;
      ch_ldc = '0;
      if (reg_wr) begin
         unique case (reg_addr)
            vcs_pkg::REG_START: start_d = reg_wdata;
            vcs_pkg::REG_CTRL: run_d = reg_wdata[0];
            vcs_pkg::REG_FLAGS: flags_d = flags_q & ~reg_wdata[2:0];
            default: ;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            vcs_pkg::REG_START: rdata_d = start_q;
            vcs_pkg::REG_CTRL: rdata_d = {31'h0, run_q};
            vcs_pkg::REG_STATUS:
               rdata_d = {19'h0, mode_q, 2'h0, state_q, sts_q};
            vcs_pkg::REG_FLAGS: rdata_d = {29'h0, flags_q};
            vcs_pkg::REG_PC: rdata_d = pc_q;
            default: rdata_d = '0;
         endcase
      end
      if (|(queue_full_flag & ~took)) begin
         flags_d[vcs_pkg::FL_OVF] = 1'b1;
      end
      if (code_pop) begin
         if (q_data[0][3:0] == vcs_pkg::CODE_PACKED) mode_d = 1'b0;
         if (q_data[0][3:0] == vcs_pkg::CODE_PLANAR) mode_d = 1'b1;
      end
      if (take && !drop_q) begin
         wr_valid_d = 1'b1;
         wr_data_d = head_word;
         wr_addr_d = cur_addr;
         wr_be_d = ins_q[0][vcs_pkg::BE_HI:vcs_pkg::BE_LO] & ch_be[cur_q];
         sol_d = first_q && ins_q[0][vcs_pkg::SOL_BIT];
         eol_d = last_chan && ch_cnt[cur_q] <= CW'(4)
            && ins_q[0][vcs_pkg::EOL_BIT];
         first_d = 1'b0;
      end
      unique case (state_q)
         vcs_pkg::ST_IDLE: begin
            if (run_q && !run_prev_q) begin
               pc_d = start_q;
               fetch_addr_d = start_q;
               fetch_req_d = 1'b1;
               widx_d = '0;
               state_d = vcs_pkg::ST_FETCH;
            end
         end
         vcs_pkg::ST_FETCH: begin
            if (fetch_ack) begin
               ins_d[widx_q] = fetch_data;
               pc_d = pc_q + vcs_pkg::WORD_BYTES;
               fetch_addr_d = pc_q + vcs_pkg::WORD_BYTES;
               widx_d = widx_q + 3'h1;
               if (widx_q + 3'h1 >= nw) begin
                  fetch_req_d = 1'b0;
                  state_d = vcs_pkg::ST_DECODE;
               end
            end
         end
         vcs_pkg::ST_DECODE: begin
            cur_d = '0;
            first_d = 1'b1;
            drop_d = 1'b0;
            state_d = vcs_pkg::ST_XFER;
            unique case (op)
               vcs_pkg::OP_WRITE: begin
                  ch_load = 3'h1;
                  ch_lda[0] = ins_q[1];
                  ch_ldc[0] = ins_q[0][vcs_pkg::CNT_HI:vcs_pkg::CNT_LO];
                  drop_d = mode_q;
               end
               vcs_pkg::OP_CONT: begin
                  ch_load = 3'h1;
                  ch_addr_en = 1'b0;
                  ch_ldc[0] = ins_q[0][vcs_pkg::CNT_HI:vcs_pkg::CNT_LO];
                  drop_d = mode_q;
               end
               vcs_pkg::OP_PLANAR: begin
                  ch_load = 3'h7;
                  ch_lda[0] = ins_q[2];
                  ch_lda[1] = ins_q[3];
                  ch_lda[2] = ins_q[4];
                  ch_ldc[0] = ins_q[0][vcs_pkg::CNT_HI:vcs_pkg::CNT_LO];
                  ch_ldc[1] = cnt2_w;
                  ch_ldc[2] = cnt3_w;
                  drop_d = !mode_q;
               end
               vcs_pkg::OP_SKIP: begin
                  ch_load = 3'h1;
                  ch_addr_en = 1'b0;
                  ch_ldc[0] = ins_q[0][vcs_pkg::CNT_HI:vcs_pkg::CNT_LO];
                  drop_d = 1'b1;
               end
               vcs_pkg::OP_SYNC: state_d = vcs_pkg::ST_SYNC;
               vcs_pkg::OP_JUMP: begin
                  pc_d = jump_tgt;
                  state_d = vcs_pkg::ST_DONE;
               end
               default: state_d = vcs_pkg::ST_DONE;
            endcase
            // A write in the wrong mode is drained, not stored
            if ((op == vcs_pkg::OP_WRITE || op == vcs_pkg::OP_CONT)
                  && mode_q) begin
               flags_d[vcs_pkg::FL_MIS] = 1'b1;
            end
            if (op == vcs_pkg::OP_PLANAR && !mode_q) begin
               flags_d[vcs_pkg::FL_MIS] = 1'b1;
            end
         end
         vcs_pkg::ST_XFER: begin
            if (ch_done[cur_q]) begin
               if (last_chan) begin
                  state_d = vcs_pkg::ST_DONE;
               end else begin
                  cur_d = cur_q + 2'h1;
               end
            end
         end
         vcs_pkg::ST_SYNC: begin
            if (sync_match) begin
               state_d = vcs_pkg::ST_DONE;
            end
         end
         vcs_pkg::ST_DONE: begin
            sts_d = (sts_q & ~ins_q[0][vcs_pkg::CLR_HI:vcs_pkg::CLR_LO])
               | ins_q[0][vcs_pkg::SET_HI:vcs_pkg::SET_LO];
            if (ins_q[0][vcs_pkg::IRQ_BIT]) begin
               flags_d[vcs_pkg::FL_IRQ] = 1'b1;
            end
            fetch_addr_d = pc_q;
            fetch_req_d = 1'b1;
            widx_d = '0;
            state_d = vcs_pkg::ST_FETCH;
         end
         default: state_d = vcs_pkg::ST_IDLE;
      endcase
      // Clearing run aborts at once; a pending write is dropped
      if (!run_q) begin
         state_d = vcs_pkg::ST_IDLE;
         fetch_req_d = 1'b0;
         wr_valid_d = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= vcs_pkg::ST_IDLE;
         start_q <= vcs_pkg::START_RST;
         run_q <= 1'b0;
         run_prev_q <= 1'b0;
         flags_q <= '0;
         sts_q <= '0;
         mode_q <= 1'b0;
         pc_q <= '0;
         for (int i = 0; i < 5; i++) begin
            ins_q[i] <= '0;
         end
         widx_q <= '0;
         cur_q <= '0;
         drop_q <= 1'b0;
         first_q <= 1'b0;
         fetch_req_q <= 1'b0;
         fetch_addr_q <= '0;
         wr_valid_q <= 1'b0;
         wr_addr_q <= '0;
         wr_data_q <= '0;
         wr_be_q <= '0;
         sol_q <= 1'b0;
         eol_q <= 1'b0;
         rdata_q <= '0;
      end else begin
         state_q <= state_d;
         start_q <= start_d;
         run_q <= run_d;
         run_prev_q <= run_q;
         flags_q <= flags_d;
         sts_q <= sts_d;
         mode_q <= mode_d;
         pc_q <= pc_d;
         for (int i = 0; i < 5; i++) begin
            ins_q[i] <= ins_d[i];
         end
         widx_q <= widx_d;
         cur_q <= cur_d;
         drop_q <= drop_d;
         first_q <= first_d;
         fetch_req_q <= fetch_req_d;
         fetch_addr_q <= fetch_addr_d;
         wr_valid_q <= wr_valid_d;
         wr_addr_q <= wr_addr_d;
         wr_data_q <= wr_data_d;
         wr_be_q <= wr_be_d;
         sol_q <= sol_d;
         eol_q <= eol_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign fetch_req = fetch_req_q;
   assign fetch_addr = fetch_addr_q;
   assign wr_valid = wr_valid_q;
   assign wr_addr = wr_addr_q;
   assign wr_data = wr_data_q;
   assign wr_be = wr_be_q;
   assign line_begin_flag = sol_q;
   assign line_end_flag = eol_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence s_sync_wait;
      state_q == vcs_pkg::ST_SYNC && !sync_match && run_q;
   endsequence
   sequence s_issue;
      take && !drop_q && run_q;
   endsequence

   property p_fetch_start;
      state_q == vcs_pkg::ST_IDLE && run_q && !run_prev_q && run_d
         |=> fetch_req_q && fetch_addr_q == $past(start_q);
   endproperty
   a_fetch_start: assert property (p_fetch_start) else $error("fetch not at start address");
   property p_full_read;
      queue_full_flag[0] |-> q_rd[0];
   endproperty
   a_full_read: assert property (p_full_read) else $error("full queue not read");
   property p_data_pass;
      s_issue |=> wr_valid_q && wr_data_q == $past(head_word);
   endproperty
   a_data_pass: assert property (p_data_pass) else $error("word not passed unshifted");
   property p_addr_lin;
      s_issue |=> wr_addr_q == $past(cur_addr) && ch_addr[$past(cur_q)]
         == wr_addr_q + vcs_pkg::WORD_BYTES;
   endproperty
   a_addr_lin: assert property (p_addr_lin) else $error("address not linear");
   property p_sync_stall;
      s_sync_wait |=> state_q == vcs_pkg::ST_SYNC || !run_q;
   endproperty
   a_sync_stall: assert property (p_sync_stall) else $error("sync left early");
   property p_irq;
      state_q == vcs_pkg::ST_DONE && ins_q[0][vcs_pkg::IRQ_BIT]
         |=> flags_q[vcs_pkg::FL_IRQ];
   endproperty
   a_irq: assert property (p_irq) else $error("irq flag not raised");
   property p_jump;
      state_q == vcs_pkg::ST_DECODE && op == vcs_pkg::OP_JUMP && run_q
         |=> pc_q == $past(jump_tgt) ##1 fetch_req_q && fetch_addr_q == $past(pc_q);
   endproperty
   a_jump: assert property (p_jump) else $error("jump not followed");
   property p_planar;
      state_q == vcs_pkg::ST_DECODE && op == vcs_pkg::OP_PLANAR && run_q
         |=> ch_cnt[1] == $past(cnt2_w) && ch_cnt[2] == $past(cnt3_w);
   endproperty
   a_planar: assert property (p_planar) else $error("chroma counts wrong");
endmodule : vcs_dma_seq
`default_nettype wire

// ---- tb/vcs_host_mem.sv ----
// Purpose: host memory reached through the bus initiator
// Assumes: program words sit at word index taken from address bits 7:2
// Notes: stall bits from the bench make each answer prompt or slow
`default_nettype none
module vcs_host_mem (
   input wire logic clk,
   input wire logic srst,
   input wire logic [1:0] stall,
   input wire logic fetch_req,
   input wire logic [31:0] fetch_addr,
   output logic fetch_ack,
   output logic [31:0] fetch_data,
   input wire logic wr_valid,
   output logic wr_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] mem [0:63];
   // Ack registered, so never two acks on one unstepped address
   always @(posedge clk) begin
      if (srst) begin
         fetch_ack <= 1'b0;
         fetch_data <= 32'h5a5a_5a5a;
      end else if (fetch_req && !fetch_ack && !stall[1]) begin
         fetch_ack <= 1'b1;
         fetch_data <= mem[fetch_addr[7:2]];
      end else begin
         fetch_ack <= 1'b0;
         // Idle data bus must not repeat the last word
         fetch_data <= ~fetch_data;
      end
   end
   // Writes land anywhere; random stalls test the hold
   assign wr_ready = wr_valid && !stall[0];
endmodule : vcs_host_mem
`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: self-checking bench of the DMA sequencer
// Assumes: bench plays the three pixel queues; host memory is a model
// Notes: data, addresses and stalls come from a fixed-seed shift register
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] S = 32'h0000_0100;
   logic clk, srst, reg_wr, reg_rd, fetch_req, fetch_ack, q_is_code, wr_valid, wr_ready;
   logic line_begin_flag, line_end_flag;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, fetch_addr, fetch_data, wr_addr, wr_data, rd;
   logic [31:0] rnd = 32'h8018;
   logic [2:0][31:0] q_data;
   logic [2:0] q_empty, queue_full_flag, q_rd;
   logic [3:0] wr_be;
   logic [31:0] qw [3][16];
   logic lc [16];
   int qn [3];
   int qi [3] = '{0, 0, 0};
   logic [31:0] ex_a [8];
   logic [31:0] ex_d [8];
   logic [5:0] ex_f [8];
   int error_cnt, n_checks;
   int nw = 0;
   int fc = 0;

   vcs_dma_seq #(.CW(12)) u_dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_ack(fetch_ack),
      .fetch_data(fetch_data), .q_data(q_data), .q_empty(q_empty),
      .queue_full_flag(queue_full_flag), .q_is_code(q_is_code), .q_rd(q_rd),
      .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .wr_be(wr_be),
      .line_begin_flag(line_begin_flag), .line_end_flag(line_end_flag), .wr_ready(wr_ready));
   vcs_host_mem u_mem (.clk(clk), .srst(srst), .stall(rnd[1:0]), .fetch_req(fetch_req),
      .fetch_addr(fetch_addr), .fetch_ack(fetch_ack), .fetch_data(fetch_data),
      .wr_valid(wr_valid), .wr_ready(wr_ready));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : results

   task automatic reg_w(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : reg_w

   task automatic reg_r(input logic [7:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      rd = reg_rdata;
   endtask : reg_r

   // Queue contents, program and expected writes
   task automatic build();
      logic [31:0] r, a;
      r = 32'h8018;
      for (int i = 0; i < 3; i++) begin
         for (int j = 0; j < 16; j++) begin
            r = lfsr(r);
            qw[i][j] = r;
            lc[j] = 1'b0;
         end
      end
      qw[0][0] = {28'h0, vcs_pkg::CODE_PACKED};
      qw[0][6] = {28'h0, vcs_pkg::CODE_PLANAR};
      lc[0] = 1'b1;
      lc[6] = 1'b1;
      a = {qw[1][9][31:2], 2'b00};
      u_mem.mem[0] = 32'h8000_0002;
      u_mem.mem[1] = 32'h1950_f00c;
      u_mem.mem[2] = a;
      u_mem.mem[3] = 32'h5400_f006;
      u_mem.mem[4] = 32'h8000_0003;
      u_mem.mem[5] = 32'h9000_f004;
      u_mem.mem[6] = 32'h0004_0004;
      u_mem.mem[7] = {qw[1][10][31:2], 2'b00};
      u_mem.mem[8] = {qw[1][11][31:2], 2'b00};
      u_mem.mem[9] = {qw[1][12][31:2], 2'b00};
      // Packed continue in planar mode and a skip: both drain, neither writes
      u_mem.mem[10] = 32'h5000_f004;
      u_mem.mem[11] = 32'h2000_f004;
      u_mem.mem[12] = 32'h7000_0000;
      u_mem.mem[13] = S;
      for (int k = 0; k < 5; k++) begin
         ex_a[k] = a + 32'(4 * k);
         ex_d[k] = qw[0][k + 1];
         // Six bytes left for continue: last word has two lanes
         ex_f[k] = {k == 0, k == 4, (k == 4) ? 4'h3 : 4'hf};
      end
      ex_d[5] = qw[0][7];
      ex_d[6] = qw[1][0];
      ex_d[7] = qw[2][0];
      for (int k = 5; k < 8; k++) begin
         ex_a[k] = u_mem.mem[k + 2];
         ex_f[k] = 6'h0f;
      end
   endtask : build

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         q_data[i] = qw[i][qi[i]];
         q_empty[i] = (qi[i] >= qn[i]);
      end
      q_is_code = lc[qi[0]] && !q_empty[0];
   end

   always @(posedge clk) begin
      rnd <= lfsr(rnd);
      for (int i = 0; i < 3; i++) begin
         // Queues hold their contents while the block is in reset
         if (q_rd[i] && !q_empty[i] && !srst) begin
            qi[i] <= qi[i] + 1;
         end
      end
      // A write past the last expected one meets unknowns and fails
      if (wr_valid && wr_ready) begin
         check(wr_addr, ex_a[nw]);
         check(wr_data, ex_d[nw]);
         check({26'h0, line_begin_flag, line_end_flag, wr_be}, {26'h0, ex_f[nw]});
         nw <= nw + 1;
      end
      if (fetch_ack && fetch_addr === S) begin
         fc <= fc + 1;
      end
   end

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      results();
   end

   initial begin
      srst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      queue_full_flag = 3'h0;
      error_cnt = 0;
      n_checks = 0;
      qn = '{10, 1, 1};
      build();
      repeat (10) @(posedge clk);
      queue_full_flag <= 3'h7;
      @(negedge clk);
      check({29'h0, q_rd}, 32'h7);
      repeat (10) @(posedge clk);
      queue_full_flag <= 3'h0;
      srst <= 1'b0;
      reg_r(vcs_pkg::REG_STATUS);
      check(rd, 32'h0000_0010);
      reg_r(8'h20);
      check(rd, 32'h0);
      reg_w(vcs_pkg::REG_START, S);
      reg_r(vcs_pkg::REG_START);
      check(rd, S);
      $display("test registers done");
      reg_w(vcs_pkg::REG_CTRL, 32'h1);
      for (int i = 0; i < 4000 && !(nw == 8 && fc == 2); i++) begin
         @(posedge clk);
      end
      repeat (8) @(posedge clk);
      check(32'(nw), 32'h8);
      check(32'(fc), 32'h2);
      reg_r(vcs_pkg::REG_STATUS);
      check(rd, 32'h0000_1105);
      reg_r(vcs_pkg::REG_FLAGS);
      check(rd, 32'h5);
      reg_w(vcs_pkg::REG_FLAGS, 32'h1);
      reg_r(vcs_pkg::REG_FLAGS);
      check(rd, 32'h4);
      $display("test program done");
      @(posedge clk);
      qn[2] <= 2;
      queue_full_flag <= 3'h4;
      @(negedge clk);
      check({31'h0, q_rd[2]}, 32'h1);
      @(posedge clk);
      queue_full_flag <= 3'h0;
      reg_r(vcs_pkg::REG_FLAGS);
      check(rd, 32'h6);
      $display("test overflow done");
      results();
   end
endmodule : tb_top
`default_nettype wire
